// [include/mmc_pkg.sv]
// Package with register layout, timing constants and states of the measurement control block
// ============================================================================
// What this block does
// [RL1] Output and oversample fields change only in standby; reboot, run and one-shot at any time outside boot.
// [RL2] Bit 7 selects barometric pressure (0, reset) or altitude (1) output.
// [RL3] Oversampling ratio is two to the power of bits 5 to 3; reset gives 1.
// [RL4] Minimum sample spacing per oversample code: 6,10,18,34,66,130,258,512 ms.
// [RL5] Writing 1 to bit 2 starts a reboot restoring all registers to defaults.
// [RL6] Reboot starts at once in standby; when active, go to standby first.
// [RL7] Reboot also resets the register access interface logic.
// [RL8] Reboot bit clears when boot ends; that bit always reads zero.
// [RL9] One-shot in active mode measures at once, then resumes periodic acquisition.
// [RL10] In active mode one-shot stays set; host clears then sets it again.
// [RL11] One-shot in standby: go active, measure once, clear bit, return to standby. Here a new one starts only after a write with bit 1 clear or a reboot.
// [RL12] Host reads back the one-shot bit before writing it again.
// [RL13] Bit 0 selects standby (0, reset) or active periodic acquisition (1).
// [RL14] Active mode period is two to the step exponent seconds; reset gives 1 s.
// [RL15] Active-mode writes ignore standby-only fields but still update run and one-shot.
package mmc_pkg;
  // ==========================================================================
  // Register map
  localparam logic [7:0] MEASUREMENT_CONTROL_ADDR = 8'h26;
  localparam logic [7:0] MEASUREMENT_CONTROL_RST  = 8'h00;
  localparam int         HEIGHT_BIT               = 7;
  localparam int         OVS_HI                   = 5;
  localparam int         OVS_LO                   = 3;
  localparam int         REBOOT_BIT               = 2;
  localparam int         ONE_SHOT_BIT             = 1;
  localparam int         RUN_BIT                  = 0;
  localparam logic [7:0] READ_MASK                = 8'hBB;
  // ==========================================================================
  // Timing
  localparam longint CLK_HZ        = 200000000;
  localparam longint CYC_PER_MS    = CLK_HZ / 1000;
  localparam longint CYC_PER_S     = CLK_HZ;
  localparam int     BOOT_CYCLES   = 16;
  // Minimum sample spacing in ms for each oversample code
  function automatic longint spacing_ms(input logic [2:0] code);
    case (code)
      3'h0: spacing_ms = 6;
      3'h1: spacing_ms = 10;
      3'h2: spacing_ms = 18;
      3'h3: spacing_ms = 34;
      3'h4: spacing_ms = 66;
      3'h5: spacing_ms = 130;
      3'h6: spacing_ms = 258;
      default: spacing_ms = 512;
    endcase
  endfunction
  // ==========================================================================
  // States
  typedef enum logic [2:0] {
    MMC_IDLE    = 3'b000,
    MMC_MEASURE = 3'b001,
    MMC_WAIT    = 3'b010,
    MMC_DRAIN   = 3'b011,
    MMC_BOOT    = 3'b100
  } mmc_state_t;
endpackage

// [verilog/mmc_timer.sv]
// Down counter that times measurements and acquisition periods
`timescale 1ns/10ps
`default_nettype none
module mmc_timer
  import mmc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        load,
  input  wire logic [47:0] value,
  output logic             done
);
  logic [47:0] count;
  // ==========================================================================
  // Load wins over counting so a restart is never missed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 48'h0;
    end else if (ce) begin
      if (load) begin
        count <= value;
      end else if (count != 48'h0) begin
        count <= count - 48'h1;
      end
    end
  end
  assign done = (count == 48'h0) && !load;
endmodule // mmc_timer
`default_nettype wire

// [verilog/mmc_control.sv]
// Measurement control register and acquisition mode sequencer
`timescale 1ns/10ps
`default_nettype none
module mmc_control
  import mmc_pkg::*;
(
  input  wire logic       CORE_CLK,
  input  wire logic       RSTN,
  input  wire logic       CE,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       XFER_ACTIVE,
  input  wire logic [3:0] ACQUISITION_PERIOD_EXPONENT,
  output logic      [7:0] REG_RDATA,
  output logic            REG_HIT,
  output logic            IF_RESET,
  output logic            BLOCK_RESET,
  output logic            HEIGHT_OUTPUT_SELECT,
  output logic      [2:0] OVERSAMPLE_EXPONENT,
  output logic      [7:0] OVERSAMPLE_RATIO,
  output logic            MEASURE_START,
  output logic            MEASURING,
  output logic            RUN_STATUS,
  output logic            BOOTING
);
  // ==========================================================================
  // Register state
  logic       height_sel;
  logic [2:0] ovs_exp;
  logic       reboot_req;
  logic       one_shot;
  logic       run_sel;
  mmc_state_t state;
  mmc_state_t next_state;
  logic [7:0] rdata;
  logic [7:0] boot_cnt;
  logic       shot_taken;

  // ==========================================================================
  // Decode
  wire ctl_hit    = (REG_ADDR == MEASUREMENT_CONTROL_ADDR);
  wire ctl_wr     = REG_WR && ctl_hit && (state != MMC_BOOT);
  wire standby    = !run_sel && (state == MMC_IDLE);
  wire cfg_wr     = ctl_wr && standby;                                 // [RL1] [RL15]
  wire boot_req   = cfg_wr && REG_WDATA[REBOOT_BIT];                   // [RL5]
  wire boot_act   = ctl_wr && !standby && REG_WDATA[REBOOT_BIT];
  wire shot_rise  = ctl_wr && REG_WDATA[ONE_SHOT_BIT] && !one_shot;    // [RL10]
  wire boot_done  = (state == MMC_BOOT) && (boot_cnt == 8'(BOOT_CYCLES - 1));
  wire timer_done;
  logic        timer_load;
  logic [47:0] timer_value;

  // Sample time and period lengths in clock cycles
  wire [47:0] meas_cycles   = 48'(spacing_ms(ovs_exp) * CYC_PER_MS);   // [RL4]
  wire [47:0] period_cycles = 48'(CYC_PER_S << ACQUISITION_PERIOD_EXPONENT); // [RL14]

  // ==========================================================================
  // Mode sequencer
  always_comb begin
    next_state  = state;
    timer_load  = 1'b0;
    timer_value = meas_cycles;
    unique case (state)
      MMC_IDLE: begin
        if (boot_req) begin
          next_state = MMC_BOOT;                                       // [RL6]
        end else if (run_sel || (one_shot && !shot_taken)) begin
          next_state = MMC_MEASURE;                                    // [RL11] [RL13]
          timer_load = 1'b1;
        end
      end
      MMC_MEASURE: begin
        if (timer_done) begin
          if (reboot_req) begin
            next_state = MMC_DRAIN;
          end else if (run_sel) begin
            next_state  = MMC_WAIT;                                    // [RL9]
            timer_load  = 1'b1;
            timer_value = (period_cycles > meas_cycles) ?
                          (period_cycles - meas_cycles) : 48'h1;
          end else begin
            next_state = MMC_IDLE;                                     // [RL11]
          end
        end
      end
      MMC_WAIT: begin
        if (reboot_req || !run_sel) begin
          next_state = reboot_req ? MMC_DRAIN : MMC_IDLE;
        end else if (shot_rise || timer_done) begin
          next_state = MMC_MEASURE;                                    // [RL9] [RL14]
          timer_load = 1'b1;
        end
      end
      MMC_DRAIN: begin
        next_state = MMC_BOOT;                                         // [RL6]
      end
      MMC_BOOT: begin
        if (boot_done) begin
          next_state = MMC_IDLE;
        end
      end
      default: next_state = MMC_IDLE;
    endcase
  end

  // ==========================================================================
  // State and boot counter
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state    <= MMC_IDLE;
      boot_cnt <= 8'h00;
    end else if (CE) begin
      state    <= next_state;
      boot_cnt <= (state == MMC_BOOT) ? boot_cnt + 8'h01 : 8'h00;
    end
  end

  // ==========================================================================
  // Control register; boot restores defaults
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      height_sel <= 1'b0;
      ovs_exp    <= 3'h0;
      reboot_req <= 1'b0;
      one_shot   <= 1'b0;
      run_sel    <= 1'b0;
    end else if (CE) begin
      if (boot_done) begin
        height_sel <= 1'b0;                                            // [RL5]
        ovs_exp    <= 3'h0;
        reboot_req <= 1'b0;                                            // [RL8]
        one_shot   <= 1'b0;
        run_sel    <= 1'b0;
      end else if (state == MMC_BOOT) begin
        run_sel <= 1'b0;
      end else begin
        if (cfg_wr) begin
          height_sel <= REG_WDATA[HEIGHT_BIT];                         // [RL2]
          ovs_exp    <= REG_WDATA[OVS_HI:OVS_LO];                      // [RL3]
        end
        if (boot_req || boot_act) begin
          reboot_req <= 1'b1;                                          // [RL6]
          run_sel    <= 1'b0;
        end else if (ctl_wr) begin
          run_sel <= REG_WDATA[RUN_BIT];                               // [RL13]
        end
        // Standby shot completion clears the bit unless a write sets it now
        if (ctl_wr) begin
          one_shot <= REG_WDATA[ONE_SHOT_BIT];
        end else if (state == MMC_MEASURE && timer_done && !run_sel) begin
          one_shot <= 1'b0;                                            // [RL11]
        end
      end
    end
  end

  // ==========================================================================
  // Remembers that a shot was served, in standby or active mode, so it is not repeated
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      shot_taken <= 1'b0;
    end else if (CE) begin
      if (ctl_wr && !REG_WDATA[ONE_SHOT_BIT]) begin
        shot_taken <= 1'b0;
      end else if (next_state == MMC_MEASURE && state != MMC_MEASURE) begin
        shot_taken <= one_shot || shot_rise;                           // [RL10]
      end else if (state == MMC_BOOT) begin
        shot_taken <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Registered read data; reboot bit reads zero
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata <= 8'h00;
    end else if (CE && REG_RD) begin
      rdata <= ctl_hit ? ({height_sel, 1'b0, ovs_exp, 1'b0, one_shot, run_sel}
                          & READ_MASK) : 8'h00;                        // [RL8]
    end
  end

  mmc_timer u_timer (
    .clk   (CORE_CLK),
    .rst_n (RSTN),
    .ce    (CE),
    .load  (timer_load),
    .value (timer_value),
    .done  (timer_done)
  );

  // ==========================================================================
  // Outputs
  assign REG_RDATA            = rdata;
  assign REG_HIT              = ctl_hit;
  assign IF_RESET             = (state == MMC_BOOT);                   // [RL7]
  assign BLOCK_RESET          = (state == MMC_BOOT);                   // [RL5]
  assign BOOTING              = (state == MMC_BOOT) || (state == MMC_DRAIN);
  assign HEIGHT_OUTPUT_SELECT = height_sel;
  assign OVERSAMPLE_EXPONENT  = ovs_exp;
  assign OVERSAMPLE_RATIO     = 8'h01 << ovs_exp;                      // [RL3]
  assign MEASURE_START        = timer_load && (next_state == MMC_MEASURE);
  assign MEASURING            = (state == MMC_MEASURE);
  assign RUN_STATUS           = (state == MMC_MEASURE) || (state == MMC_WAIT);
  // XFER_ACTIVE is accepted but unused; IF_RESET follows the boot state alone
  wire unused_ok = XFER_ACTIVE;
endmodule // mmc_control
`default_nettype wire

// [tb/mmc_control_monitor.sv]
// Checker of the measurement control block ports
`timescale 1ns/10ps
`default_nettype none
module mmc_control_monitor (
  input wire logic       CORE_CLK,
  input wire logic       RSTN,
  input wire logic       REG_WR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  input wire logic       REG_HIT,
  input wire logic       IF_RESET,
  input wire logic       BLOCK_RESET,
  input wire logic       HEIGHT_OUTPUT_SELECT,
  input wire logic [2:0] OVERSAMPLE_EXPONENT,
  input wire logic [7:0] OVERSAMPLE_RATIO,
  input wire logic       MEASURE_START,
  input wire logic       MEASURING,
  input wire logic       RUN_STATUS,
  input wire logic       BOOTING
);
  // ==========================================================================
  // Boot length counter, cheaper than a long repetition
  logic [7:0] boot_cnt;
  always_ff @(posedge CORE_CLK or negedge RSTN)
    if (!RSTN) boot_cnt <= 8'h00;
    else boot_cnt <= IF_RESET ? boot_cnt + 8'h01 : 8'h00;
  // Write taken while nothing runs
  wire idle_wr = REG_WR && REG_HIT && !RUN_STATUS && !BOOTING && !MEASURING;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  ratio_map_a: assert property (OVERSAMPLE_RATIO == (8'h01 << OVERSAMPLE_EXPONENT))
    else $error("ratio mismatch");
  rd_zero_a: assert property (REG_RDATA[6] == 1'b0 && REG_RDATA[2] == 1'b0)
    else $error("zero bits read high");
  boot_len_a: assert property ($fell(IF_RESET) |-> boot_cnt == 8'h10)
    else $error("boot length wrong");
  reset_pair_a: assert property (IF_RESET == BLOCK_RESET)
    else $error("resets differ");
  start_pulse_a: assert property (MEASURE_START |=> MEASURING && !MEASURE_START)
    else $error("start pulse wrong");
  shot_go_a: assert property (idle_wr && REG_WDATA[1:0] != 2'h0 && !REG_WDATA[2]
    |=> MEASURE_START) else $error("measurement not started");
  idle_write_a: assert property (idle_wr && REG_WDATA[2:0] == 3'h0
    |=> HEIGHT_OUTPUT_SELECT == $past(REG_WDATA[7])
        && OVERSAMPLE_EXPONENT == $past(REG_WDATA[5:3])) else $error("field not written");
  frozen_cfg_a: assert property (RUN_STATUS ##1 RUN_STATUS
    |-> $stable(OVERSAMPLE_EXPONENT) && $stable(HEIGHT_OUTPUT_SELECT))
    else $error("field changed while active");
  cover property (MEASURE_START);
  cover property ($fell(IF_RESET));
  cover property (RUN_STATUS && REG_WR && REG_HIT);
endmodule // mmc_control_monitor
`default_nettype wire

// [tb/mmc_host_model.sv]
// Host model issuing register cycles on the strobe interface
`timescale 1ns/10ps
`default_nettype none
module mmc_host_model (
  input  wire logic       CORE_CLK,
  input  wire logic [7:0] REG_RDATA,
  output logic            REG_WR,
  output logic            REG_RD,
  output logic      [7:0] REG_ADDR,
  output logic      [7:0] REG_WDATA
);
  // ==========================================================================
  // Idle bus shows inverted last values so stale bytes never look fresh
  initial begin
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_ADDR = 8'h00;
    REG_WDATA = 8'h00;
  end
  // Callers touch standby-only fields only in standby, except refusal tests
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CORE_CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CORE_CLK);
    REG_WR <= 1'b0;
    REG_ADDR <= ~a;
    REG_WDATA <= ~d;
  endtask
  // Data lands on the same edge that samples the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CORE_CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CORE_CLK);
    REG_RD <= 1'b0;
    REG_ADDR <= ~a;
    #1 d = REG_RDATA;
  endtask
endmodule // mmc_host_model
`default_nettype wire

// [tb/mmc_control_bench.sv]
// Self-checking bench of the measurement control block
`timescale 1ns/10ps
`default_nettype none
module mmc_control_bench
  import mmc_pkg::*;
;
  logic       CORE_CLK = 1'b0;
  logic       RSTN = 1'b0;
  logic [3:0] ACQUISITION_PERIOD_EXPONENT = 4'h0;
  logic       REG_WR, REG_RD, REG_HIT, IF_RESET, BLOCK_RESET, HEIGHT_OUTPUT_SELECT;
  logic       MEASURE_START, MEASURING, RUN_STATUS, BOOTING;
  logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, OVERSAMPLE_RATIO;
  logic [2:0] OVERSAMPLE_EXPONENT;
  int         mismatches = 0;
  int         comparisons = 0;
  // ==========================================================================
  // Clock at 200 MHz
  always #2.5 CORE_CLK = ~CORE_CLK;
  mmc_control i_mmc_control (
    .CORE_CLK, .RSTN, .CE(1'b1), .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA,
    .XFER_ACTIVE(1'b0), .ACQUISITION_PERIOD_EXPONENT, .REG_RDATA, .REG_HIT,
    .IF_RESET, .BLOCK_RESET, .HEIGHT_OUTPUT_SELECT, .OVERSAMPLE_EXPONENT,
    .OVERSAMPLE_RATIO, .MEASURE_START, .MEASURING, .RUN_STATUS, .BOOTING);
  mmc_host_model i_mmc_host_model (
    .CORE_CLK, .REG_RDATA, .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_mmc_host_model.rd(a, d);
    chk(d, e);
  endtask
  task automatic do_reset;
    @(posedge CORE_CLK);
    RSTN <= 1'b0;
    repeat (6) @(posedge CORE_CLK);
    RSTN <= 1'b1;
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Tests take about 100 cycles; a hang is cut well after that
  initial begin
    repeat (20000) @(posedge CORE_CLK);
    mismatches++;
    finish_test();
  end
  // Long measurements never end in this run, so each busy test ends by reset
  initial begin
    logic [7:0] n;
    do_reset();
    ACQUISITION_PERIOD_EXPONENT <= 4'h3;
    rdchk(8'h26, 8'h00);
    rdchk(8'h27, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      i_mmc_host_model.wr(8'h26, {i[0], 1'b1, i[2:0], 3'h0});
      rdchk(8'h26, {i[0], 1'b0, i[2:0], 3'h0});
      chk(OVERSAMPLE_RATIO, 8'h01 << i[2:0]);
    end
    $display("test standby fields done");
    i_mmc_host_model.wr(8'h26, 8'h02);
    #1 chk({7'h00, MEASURE_START}, 8'h01);
    rdchk(8'h26, 8'h02);
    i_mmc_host_model.wr(8'h26, 8'hBA);
    rdchk(8'h26, 8'h02);
    do_reset();
    rdchk(8'h26, 8'h00);
    $display("test standby shot done");
    i_mmc_host_model.wr(8'h26, 8'h01);
    // The sequencer leaves idle one edge after the run bit lands
    @(posedge CORE_CLK);
    #1 chk({7'h00, RUN_STATUS}, 8'h01);
    i_mmc_host_model.wr(8'h26, 8'hB9);
    rdchk(8'h26, 8'h01);
    i_mmc_host_model.wr(8'h26, 8'h03);
    rdchk(8'h26, 8'h03);
    i_mmc_host_model.wr(8'h26, 8'h04);
    // Boot is deferred until the running measurement ends
    #1 chk({6'h00, BOOTING, RUN_STATUS}, 8'h01);
    do_reset();
    $display("test active mode done");
    i_mmc_host_model.wr(8'h26, 8'hA8);
    i_mmc_host_model.wr(8'h26, 8'h04);
    #1 chk({6'h00, IF_RESET, BLOCK_RESET}, 8'h03);
    i_mmc_host_model.wr(8'h26, 8'h98);
    #1 n = 8'h00;
    while (IF_RESET === 1'b1 && n < 8'd40) begin
      @(posedge CORE_CLK);
      #1 n++;
    end
    chk(n, 8'(BOOT_CYCLES - 2));
    rdchk(8'h26, 8'h00);
    $display("test reboot done");
    finish_test();
  end
endmodule // mmc_control_bench
bind mmc_control mmc_control_monitor i_mmc_control_monitor (
  .CORE_CLK, .RSTN, .REG_WR, .REG_WDATA, .REG_RDATA, .REG_HIT, .IF_RESET,
  .BLOCK_RESET, .HEIGHT_OUTPUT_SELECT, .OVERSAMPLE_EXPONENT, .OVERSAMPLE_RATIO,
  .MEASURE_START, .MEASURING, .RUN_STATUS, .BOOTING);
`default_nettype wire
